// ---- rtl/srb_pkg.sv ----
// Purpose: shared constants for the serial radio bridge controller
// Assumes: 100 MHz clock
// Notes: register indices are word offsets on the plain register port
package srb_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int ADDR_W = 4;
    // register offsets
    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_SERCFG = 4'h1;
    localparam logic [3:0] REG_PEER_LO = 4'h2;
    localparam logic [3:0] REG_PEER_HI = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CTRL = 4'h5;
    localparam logic [3:0] REG_TXDATA = 4'h6;
    // serial config field positions
    localparam int CFG_BAUD_LSB = 0;
    localparam int CFG_PAR_LSB = 4;
    localparam int CFG_STOP2_BIT = 6;
    localparam int CFG_HWFC_BIT = 7;
    localparam logic [7:0] SERCFG_RESET = 8'h03;
    // control bit positions (write one to pulse)
    localparam int CTRL_SWRST_BIT = 0;
    localparam int CTRL_HWRST_BIT = 1;
    localparam int CTRL_CONN_OK_BIT = 2;
    localparam int CTRL_DRAIN_BIT = 3;
    // data bits fixed at eight
    localparam int DATA_BITS = 8;
    localparam int PEER_W = 48;
    // transmit buffer
    localparam int BUF_DEPTH = 16;
    localparam int BUF_AW = 4;
    localparam logic [4:0] BUF_LOW_MARK = 5'h08;
    typedef enum logic [1:0] {
        SRB_IDLE_CMD,
        SRB_CONNECT_LAST,
        SRB_WAIT_LAST,
        SRB_OPEN_SLAVE
    } srb_mode_t;
    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} srb_par_t;
    // baud divisor, clocks per bit (38200 kept as listed)
    function automatic logic [16:0] baud_div(input logic [3:0] sel);
        unique case (sel)
            4'h0: baud_div = 17'(CLK_HZ / 1200);
            4'h1: baud_div = 17'(CLK_HZ / 2400);
            4'h2: baud_div = 17'(CLK_HZ / 4800);
            4'h3: baud_div = 17'(CLK_HZ / 9600);
            4'h4: baud_div = 17'(CLK_HZ / 19200);
            4'h5: baud_div = 17'(CLK_HZ / 38200);
            4'h6: baud_div = 17'(CLK_HZ / 57600);
            4'h7: baud_div = 17'(CLK_HZ / 115200);
            default: baud_div = 17'(CLK_HZ / 230400);
        endcase
    endfunction
endpackage

// ---- rtl/srb_ctrl.sv ----
// Purpose: serial side of a wireless serial bridge: mode control, peer store,
//          serial receiver with framing options, transmit buffer, rts flow control
// Assumes: single 100 MHz clock, async active-low reset
// Notes: radio side is abstracted as a drain strobe and status outputs
// How it works
// [R1] idle command mode: silent, waits for text
// [R2] idle: no role, configuration writes accepted
// [R3] host selects idle mode before text commands
// [R4] mode defaults to idle command mode
// [R5] peer address: one 48-bit stored value
// [R6] store last peer on each connection
// [R7] hard reset clears stored peer
// [R8] host picks master mode after a connection
// [R9] master mode: connect to stored peer
// [R10] master mode: not discoverable nor connectable
// [R11] wait mode: slave, stored peer only
// [R12] wait mode: refuse all other peers
// [R13] open slave: discoverable, accepts anyone
// [R14] nine selectable baud rates
// [R15] always eight data bits
// [R16] parity none/even/odd, one or two stops
// [R17] seven-bit hosts use eight bits, no parity
// [R18] buffer host data until delivered
// [R19] flow control: drop rts when full
// [R20] flow control: raise rts when room
// [R21] no flow control: clear buffer when full
// [R22] host advised to use flow control
// [R23] host stops sending while rts low
// [R24] rts rises only below low mark
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module srb_ctrl
    import srb_pkg::*;
(
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [srb_pkg::ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic rxd_i,
    output logic rts_o,
    input wire logic [srb_pkg::PEER_W-1:0] conn_peer_i,
    output logic [7:0] tx_byte_o,
    output logic tx_valid_o,
    output logic master_o,
    output logic slave_o,
    output logic discoverable_o,
    output logic peer_filter_o,
    output logic [srb_pkg::PEER_W-1:0] peer_addr_o,
    output logic peer_valid_o,
    output logic connect_req_o
);
    import srb_pkg::*;

    srb_mode_t mode;
    logic [7:0] sercfg;
    logic [PEER_W-1:0] peer;
    logic peer_ok;
    logic restart;
    logic rx_s1, rx_s2;
    logic [7:0] mem [BUF_DEPTH];
    logic [BUF_AW-1:0] wptr, rptr;
    logic [4:0] count;
    logic rx_done;
    logic [7:0] rx_byte;
    logic push, pop, flush;
    logic ctrl_wr;

    assign ctrl_wr = wr_i && addr_i == REG_CTRL;

    ////////////////////////////////////////////////////////////////////////
    // mode register; writes only change behaviour, no reply is sent
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode <= SRB_IDLE_CMD; // R4
        end else if (wr_i && addr_i == REG_MODE) begin
            mode <= srb_mode_t'(wdata_i[1:0]); // R2
        end
    end

    // configuration is kept in all modes; host drops to idle first for text
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sercfg <= SERCFG_RESET;
        end else if (wr_i && addr_i == REG_SERCFG) begin
            sercfg <= wdata_i[7:0]; // R14 R16
        end
    end

    // peer store: hardware reset wipes it, each connection refreshes it
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            peer <= '0;
            peer_ok <= 1'b0;
        end else if (ctrl_wr && wdata_i[CTRL_CONN_OK_BIT]) begin
            peer <= conn_peer_i; // R5 R6
            peer_ok <= 1'b1;
        end else if (ctrl_wr && wdata_i[CTRL_HWRST_BIT]) begin
            peer <= '0; // R7
            peer_ok <= 1'b0;
        end
    end

    // restart pulse after reset release or software reset
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            restart <= 1'b1;
        end else begin
            restart <= ctrl_wr && wdata_i[CTRL_SWRST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // role outputs decoded from mode; idle takes no role
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            master_o <= 1'b0;
            slave_o <= 1'b0;
            discoverable_o <= 1'b0;
            peer_filter_o <= 1'b0;
            connect_req_o <= 1'b0;
        end else begin
            master_o <= mode == SRB_CONNECT_LAST; // R9 R2
            slave_o <= mode == SRB_WAIT_LAST || mode == SRB_OPEN_SLAVE; // R11
            discoverable_o <= mode == SRB_OPEN_SLAVE; // R10 R12 R13
            peer_filter_o <= mode == SRB_WAIT_LAST; // R12
            // without a stored peer master mode sends no connect request; wait mode still filters
            connect_req_o <= restart && mode == SRB_CONNECT_LAST && peer_ok; // R9 R8 R1
        end
    end

    assign peer_addr_o = peer;
    assign peer_valid_o = peer_ok;

    ////////////////////////////////////////////////////////////////////////
    // receive pin synchroniser; first stage read only by second
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= rxd_i;
            rx_s2 <= rx_s1;
        end
    end

    // receiver: 8 data bits always; parity and stop length as configured
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} srb_rx_t;
    srb_rx_t rx_st;
    logic [16:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic rx_stop2;
    logic [16:0] div;
    srb_par_t par;

    assign div = baud_div(sercfg[CFG_BAUD_LSB +: 4]); // R14
    assign par = srb_par_t'(sercfg[CFG_PAR_LSB +: 2]);

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_st <= RX_IDLE;
            rx_cnt <= '0;
            rx_bit <= '0;
            rx_sh <= '0;
            rx_perr <= 1'b0;
            rx_stop2 <= 1'b0;
            rx_done <= 1'b0;
            rx_byte <= '0;
        end else begin
            rx_done <= 1'b0;
            unique case (rx_st)
                RX_IDLE: begin
                    if (!rx_s2) begin
                        rx_st <= RX_START;
                        rx_cnt <= {1'b0, div[16:1]};
                    end
                end
                RX_START: begin
                    if (rx_cnt == 0) begin
                        rx_st <= rx_s2 ? RX_IDLE : RX_DATA;
                        rx_cnt <= div - 17'd1;
                        rx_bit <= '0;
                        rx_perr <= par == PAR_ODD;
                    end else begin
                        rx_cnt <= rx_cnt - 17'd1;
                    end
                end
                RX_DATA: begin
                    if (rx_cnt == 0) begin
                        rx_sh <= {rx_s2, rx_sh[7:1]};
                        rx_perr <= rx_perr ^ rx_s2;
                        rx_cnt <= div - 17'd1;
                        rx_bit <= rx_bit + 3'd1;
                        if (rx_bit == 3'(DATA_BITS - 1)) begin // R15
                            rx_st <= (par == PAR_NONE) ? RX_STOP : RX_PAR;
                            rx_stop2 <= sercfg[CFG_STOP2_BIT]; // R16
                        end
                    end else begin
                        rx_cnt <= rx_cnt - 17'd1;
                    end
                end
                RX_PAR: begin
                    if (rx_cnt == 0) begin
                        rx_perr <= rx_perr ^ rx_s2; // R16
                        rx_cnt <= div - 17'd1;
                        rx_st <= RX_STOP;
                    end else begin
                        rx_cnt <= rx_cnt - 17'd1;
                    end
                end
                RX_STOP: begin
                    if (rx_cnt == 0) begin
                        if (rx_stop2) begin
                            rx_stop2 <= 1'b0;
                            rx_cnt <= div - 17'd1;
                        end else begin
                            rx_st <= RX_IDLE;
                            // bad frames are discarded
                            rx_done <= rx_s2 && (par == PAR_NONE || !rx_perr);
                            rx_byte <= rx_sh;
                        end
                    end else begin
                        rx_cnt <= rx_cnt - 17'd1;
                    end
                end
                default: rx_st <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer; data stays until the radio side drains it, unless flow control is off and a full buffer is dumped
    logic hwfc;
    logic full;
    assign hwfc = sercfg[CFG_HWFC_BIT];
    assign full = count == 5'(BUF_DEPTH);
    assign push = (rx_done || (wr_i && addr_i == REG_TXDATA)) && !full;
    assign pop = ctrl_wr && wdata_i[CTRL_DRAIN_BIT] && count != 0;
    // without flow control a full buffer is dumped; data may be lost
    assign flush = !hwfc && full; // R21

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wptr] <= rx_done ? rx_byte : wdata_i[7:0]; // R18
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else if (flush) begin
            wptr <= '0; // R21
            rptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wptr <= wptr + 1'b1;
            end
            if (pop) begin
                rptr <= rptr + 1'b1;
            end
            count <= count + 5'(push) - 5'(pop); // R18
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_byte_o <= '0;
        end else begin
            tx_byte_o <= mem[rptr];
        end
    end
    assign tx_valid_o = count != 0;

    // rts with hysteresis so it does not chatter per byte
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rts_o <= 1'b1;
        end else if (!hwfc) begin
            rts_o <= 1'b1;
        end else if (count == 5'(BUF_DEPTH) || (push && count == 5'(BUF_DEPTH - 1))) begin
            rts_o <= 1'b0; // R19 R23
        end else if (count < BUF_LOW_MARK) begin
            rts_o <= 1'b1; // R20 R24
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                REG_MODE: rdata_o <= {30'h0, mode};
                REG_SERCFG: rdata_o <= {24'h0, sercfg};
                REG_PEER_LO: rdata_o <= peer[31:0];
                REG_PEER_HI: rdata_o <= {16'h0, peer[47:32]};
                REG_STATUS: rdata_o <= {25'h0, peer_ok, rts_o, count};
                default: rdata_o <= '0;
            endcase
        end else begin
            rdata_o <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_idle_role;
        @(posedge clock_i) disable iff (!resetn_i)
        mode == SRB_IDLE_CMD |=> !master_o && !slave_o;
    endproperty
    a_idle_role: assert property (p_idle_role) else $error("idle mode took a role"); // R2

    property p_master_hidden;
        @(posedge clock_i) disable iff (!resetn_i)
        $past(mode) == SRB_CONNECT_LAST && mode == SRB_CONNECT_LAST |-> !discoverable_o;
    endproperty
    a_master_hidden: assert property (p_master_hidden) else $error("master discoverable"); // R10

    property p_wait_filter;
        @(posedge clock_i) disable iff (!resetn_i)
        mode == SRB_WAIT_LAST |=> peer_filter_o && slave_o && !discoverable_o;
    endproperty
    a_wait_filter: assert property (p_wait_filter) else $error("wait mode not filtered"); // R12

    property p_open;
        @(posedge clock_i) disable iff (!resetn_i)
        mode == SRB_OPEN_SLAVE |=> discoverable_o && !peer_filter_o;
    endproperty
    a_open: assert property (p_open) else $error("open slave hidden"); // R13

    property p_store;
        @(posedge clock_i) disable iff (!resetn_i)
        ctrl_wr && wdata_i[CTRL_CONN_OK_BIT] |=> peer_ok && peer == $past(conn_peer_i);
    endproperty
    a_store: assert property (p_store) else $error("peer not stored"); // R6

    property p_rts_full;
        @(posedge clock_i) disable iff (!resetn_i)
        hwfc && full |=> !rts_o;
    endproperty
    a_rts_full: assert property (p_rts_full) else $error("rts high while full"); // R19

    property p_rts_hyst;
        @(posedge clock_i) disable iff (!resetn_i)
        hwfc && !rts_o && count >= BUF_LOW_MARK |=> !rts_o;
    endproperty
    a_rts_hyst: assert property (p_rts_hyst) else $error("rts rose above mark"); // R24

    property p_flush;
        @(posedge clock_i) disable iff (!resetn_i)
        !hwfc && full |=> count == 0;
    endproperty
    a_flush: assert property (p_flush) else $error("buffer not cleared"); // R21

    // idle mode never starts a link on its own, restart or not
    property p_idle_silent;
        @(posedge clock_i) disable iff (!resetn_i)
        mode == SRB_IDLE_CMD |=> !connect_req_o;
    endproperty
    a_idle_silent: assert property (p_idle_silent) else $error("idle mode sent a request"); // R1

    // a connect request needs a stored peer and the master role
    property p_req_peer;
        @(posedge clock_i) disable iff (!resetn_i)
        connect_req_o |-> $past(peer_ok) && master_o;
    endproperty
    a_req_peer: assert property (p_req_peer) else $error("request without stored peer"); // R7

    // once below the low mark the host is let back in
    property p_rts_resume;
        @(posedge clock_i) disable iff (!resetn_i)
        hwfc && !rts_o && count < BUF_LOW_MARK |=> rts_o;
    endproperty
    a_rts_resume: assert property (p_rts_resume) else $error("rts stuck low below mark"); // R20
endmodule

// ---- test/srb_host_model.sv ----
// Purpose: host system serial port that feeds the bridge controller
// Assumes: bit time given in clocks, line idles high
// Notes: frames start only while rts is high; a bad parity bit is sent on request
`timescale 1ns/1ps
module srb_host_model #(
    parameter int BIT_CLKS = 434
) (
    input wire logic clock_i,
    input wire logic rts_i,
    output logic txd_o
);
    initial txd_o = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // one bit time on the line, changed right after an edge
    task automatic put(input logic b);
        txd_o <= b;
        repeat (BIT_CLKS) @(posedge clock_i);
    endtask

    // always eight data bits, lsb first; seven-bit users map onto this
    task automatic send(input logic [7:0] d, input int par, input bit stop2, input bit bad);
        logic p;
        @(posedge clock_i);
        while (rts_i !== 1'b1) @(posedge clock_i);
        p = ^d ^ (par == 2) ^ bad;
        put(1'b0);
        for (int i = 0; i < 8; i++) put(d[i]);
        if (par != 0) put(p);
        put(1'b1);
        if (stop2) put(1'b1);
    endtask
endmodule

// ---- test/serial_radio_bridge_ctrl_tb.sv ----
// Purpose: self-checking bench for the serial radio bridge controller
// Assumes: 100 MHz clock, fastest baud so frames stay short
// Notes: buffer filled through the data register to keep the run brief
`timescale 1ns/1ps
module serial_radio_bridge_ctrl_tb;
    import srb_pkg::*;
    logic clock_i = 0;
    logic resetn_i = 0;
    logic [3:0] addr_i = '0;
    logic [31:0] wdata_i = '0;
    logic wr_i = 0;
    logic rd_i = 0;
    logic [47:0] conn_peer_i = '0;
    logic [31:0] rdata_o, rv;
    logic [7:0] tx_byte_o;
    logic [47:0] peer_addr_o;
    logic rxd_i, rts_o, tx_valid_o, master_o, slave_o, discoverable_o;
    logic peer_filter_o, peer_valid_o, connect_req_o;
    int fails = 0;
    int cmp_count = 0;
    int req_seen = 0;

    srb_ctrl DUT (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rxd_i(rxd_i), .rts_o(rts_o), .conn_peer_i(conn_peer_i),
        .tx_byte_o(tx_byte_o), .tx_valid_o(tx_valid_o), .master_o(master_o),
        .slave_o(slave_o), .discoverable_o(discoverable_o),
        .peer_filter_o(peer_filter_o), .peer_addr_o(peer_addr_o),
        .peer_valid_o(peer_valid_o), .connect_req_o(connect_req_o));
    srb_host_model #(.BIT_CLKS(434)) host (.clock_i(clock_i), .rts_i(rts_o), .txd_o(rxd_i));

    initial begin
        forever #5 clock_i = ~clock_i;
    end

    // connect requests are counted so a double pulse shows up too
    always @(posedge clock_i) begin
        if (connect_req_o === 1'b1) req_seen <= req_seen + 1;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        if (fails == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [47:0] e, input logic [47:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        // let the edge settle so a check right after a write sees the new state
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1 rv = rdata_o;
    endtask

    task automatic count_is(input int n);
        rd(REG_STATUS);
        chk("count", 48'(n), 48'(rv[4:0]));
    endtask

    // soft reset, then count connect requests over a short window
    task automatic restart(input int n);
        req_seen = 0;
        wr(REG_CTRL, 32'h0000_0001);
        repeat (4) @(posedge clock_i);
        chk("connect_req", 48'(n), 48'(req_seen));
    endtask

    task automatic drain(input int n);
        repeat (n) wr(REG_CTRL, 32'h0000_0008);
        repeat (2) @(posedge clock_i);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // expected role bits per mode: master, slave, discoverable
    logic [2:0] role_exp [4] = '{3'b000, 3'b100, 3'b010, 3'b011};

    initial begin
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        rd(REG_MODE);
        chk("mode", 48'h0, 48'(rv));
        rd(REG_SERCFG);
        chk("sercfg", 48'(SERCFG_RESET), 48'(rv));
        rd(REG_STATUS);
        chk("status", 48'h0020, 48'(rv));
        rd(4'hF);
        chk("unmapped", 48'h0, 48'(rv));
        restart(0);
        chk("roles", 48'h0, 48'({master_o, slave_o, discoverable_o}));
        wr(REG_SERCFG, 32'h0000_0008);
        rd(REG_SERCFG);
        chk("sercfg", 48'h08, 48'(rv));
        wr(REG_MODE, 32'h0000_0001);
        restart(0);
        conn_peer_i <= 48'h1234_5678_9abc;
        wr(REG_CTRL, 32'h0000_0004);
        rd(REG_PEER_LO);
        chk("peer_lo", 48'h5678_9abc, 48'(rv));
        rd(REG_PEER_HI);
        chk("peer_hi", 48'h1234, 48'(rv));
        conn_peer_i <= 48'h0f0e_0d0c_0b0a;
        wr(REG_CTRL, 32'h0000_0004);
        chk("peer_addr", 48'h0f0e_0d0c_0b0a, peer_addr_o);
        chk("peer_valid", 48'h1, 48'(peer_valid_o));
        restart(1);
        for (int m = 0; m < 4; m++) begin
            wr(REG_MODE, 32'(m));
            repeat (2) @(posedge clock_i);
            chk("roles", 48'(role_exp[m]), 48'({master_o, slave_o, discoverable_o}));
            if (m >= 2) chk("filter", 48'(m == 2), 48'(peer_filter_o));
        end
        wr(REG_CTRL, 32'h0000_0002);
        chk("peer_valid", 48'h0, 48'(peer_valid_o));
        wr(REG_MODE, 32'h0000_0000);
        // serial frames at the fastest rate: no parity, even parity with two stops (good then bad), odd parity
        host.send(8'ha5, 0, 0, 0);
        repeat (20) @(posedge clock_i);
        count_is(1);
        chk("head", 48'ha5, 48'(tx_byte_o));
        wr(REG_SERCFG, 32'h0000_0058);
        host.send(8'h3c, 1, 1, 0);
        host.send(8'h3c, 1, 1, 1);
        repeat (20) @(posedge clock_i);
        count_is(2);
        wr(REG_SERCFG, 32'h0000_0028);
        host.send(8'h81, 2, 0, 0);
        repeat (20) @(posedge clock_i);
        count_is(3);
        drain(1);
        chk("head", 48'h3c, 48'(tx_byte_o));
        drain(1);
        chk("head", 48'h81, 48'(tx_byte_o));
        drain(1);
        chk("valid", 48'h0, 48'(tx_valid_o));
        // flow control on: fill, then drain across the low mark
        wr(REG_SERCFG, 32'h0000_0088);
        for (int i = 0; i < 16; i++) wr(REG_TXDATA, 32'(i));
        repeat (2) @(posedge clock_i);
        chk("rts", 48'h0, 48'(rts_o));
        count_is(16);
        drain(8);
        chk("rts", 48'h0, 48'(rts_o));
        drain(1);
        chk("rts", 48'h1, 48'(rts_o));
        drain(7);
        // flow control off: a full buffer is thrown away
        wr(REG_SERCFG, 32'h0000_0008);
        for (int i = 0; i < 16; i++) wr(REG_TXDATA, 32'(i));
        repeat (3) @(posedge clock_i);
        count_is(0);
        chk("valid", 48'h0, 48'(tx_valid_o));
        conclude();
    end

    // frames take about 19.5k cycles; allow well over double
    initial begin
        #600_000;
        fails++;
        conclude();
    end
endmodule
